// File: logic/lsd_pkg.sv
// lsd_pkg: constants and carriers for the logic, shift and move datapath.
// assumes: one 125 MHz core clock; a decoder supplies one operation per cycle.

package lsd_pkg;

    // ----------------------------------------
    // register port map and reset values
    // ----------------------------------------
    localparam logic [7:0] REG_FLAGS_OFF = 8'h00;
    localparam logic [7:0] REG_RESULT_OFF = 8'h04;
    localparam logic [7:0] REG_COUNT_OFF = 8'h08;
    localparam logic [31:0] RESULT_RESET = 32'h00000000;
    localparam logic [31:0] COUNT_RESET = 32'h00000000;
    localparam logic [3:0] FLAGS_RESET = 4'h0;

    // ----------------------------------------
    // field positions and operand limits
    // ----------------------------------------
    localparam int FLAG_N_BIT = 3;
    localparam int FLAG_Z_BIT = 2;
    localparam int FLAG_C_BIT = 1;
    localparam int FLAG_V_BIT = 0;
    localparam logic [5:0] IMM_RIGHT_MIN = 6'h01;
    localparam logic [5:0] IMM_RIGHT_MAX = 6'h20;
    localparam logic [5:0] IMM_LEFT_MAX = 6'h1F;
    localparam logic [5:0] LZ_ALL_ZERO = 6'h20;

    // operations, one-hot
    typedef enum logic [16:0] {
        op_and = 17'h00001,
        op_bitwise_or = 17'h00002,
        op_bitwise_xor = 17'h00004,
        op_clear_masked_bits = 17'h00008,
        op_or_with_inverse = 17'h00010,
        op_arith_right_shift = 17'h00020,
        op_logical_left_shift = 17'h00040,
        op_logical_right_shift = 17'h00080,
        op_rotate_right = 17'h00100,
        op_rotate_through_carry = 17'h00200,
        op_leading_zero_count = 17'h00400,
        op_compare_subtract = 17'h00800,
        op_compare_add = 17'h01000,
        op_copy_value = 17'h02000,
        op_inverted_copy = 17'h04000,
        op_upper_half_load = 17'h08000,
        op_wide_immediate_load = 17'h10000
    } lsd_op_type;

    // shift form attached to a copy_value, one-hot
    typedef enum logic [4:0] {
        mk_plain = 5'h01,
        mk_arith_right_shift = 5'h02,
        mk_logical_left_shift = 5'h04,
        mk_logical_right_shift = 5'h08,
        mk_rotate_right = 5'h10
    } lsd_move_shift_type;

    typedef struct packed {
        logic n;
        logic z;
        logic c;
        logic v;
    } lsd_flags_type;

    typedef struct packed {
        logic valid;
        lsd_op_type op;
        logic set_flags;
        logic amount_from_register;
        lsd_move_shift_type move_shift;
        logic [31:0] first_operand;
        logic [31:0] flexible_operand;
        logic flexible_carry;
        logic flexible_shifted;
        logic [31:0] source_operand;
        logic [31:0] shift_amount_register;
        logic [5:0] immediate_amount;
        logic [15:0] immediate_value;
        logic [31:0] dest_old;
        logic dest_is_pc;
        logic dest_is_sp;
    } lsd_req_type;

    typedef struct packed {
        logic done;
        logic write_en;
        logic rejected;
        logic branch;
        logic [31:0] result;
        logic [31:0] branch_addr;
    } lsd_rsp_type;

    typedef struct packed {
        logic [31:0] value;
        logic carry;
    } lsd_shout_type;

    typedef struct packed {
        lsd_rsp_type rsp;
        lsd_flags_type flags;
        logic [31:0] last_result;
        logic [31:0] op_count;
        logic [31:0] rd_data;
    } lsd_state_type;

endpackage : lsd_pkg

// File: logic/lsd_datapath.sv
// lsd_datapath: logical, shift, count, compare and move datapath of the core.
// assumes: decoder drives req for one cycle per operation; flexible operand
// and its carry are already formed upstream; registers read on a plain port.
// Behaviour
// [RL1] and, xor, or of first operand with flexible operand.
// [RL2] clear_masked_bits ands first operand with inverted flexible operand.
// [RL3] or_with_inverse ors first operand with inverted flexible operand.
// [RL4] logical and move flag update: n, z from result, c from operand, v kept.
// [RL5] register shift amount uses only the low byte, zero to 255.
// [RL6] immediate amounts 1..32 for right shifts, 0..31 for left and rotate.
// [RL7] rotate_through_carry shifts the source right by one place.
// [RL8] shifts write only the destination; source operand stays untouched.
// [RL9] shift flags: n, z from result, c last out, kept at amount zero.
// [RL10] leading zero count gives 32 for zero, 0 with top bit set; no flags.
// [RL11] compare_subtract sets flags like subtraction and writes nothing.
// [RL12] compare_add sets flags like addition and writes nothing.
// [RL13] both compares always update all four flags.
// [RL14] copy_value copies flexible operand; wide load zero-extends 16 bits.
// [RL15] inverted_copy writes the inverse of the flexible operand.
// [RL16] copy with shift form behaves as the matching shift operation.
// [RL17] copy to program counter branches with bit 0 forced to zero.
// [RL18] copies using sp or pc take plain register, no flag update.
// [RL19] upper_half_load sets bits 31..16, keeps 15..0 and flags.
// [RL20] arith shift fills with sign; rotate_through_carry inserts old carry.
//
// Our own choices: strobed register access and the register offsets.

`timescale 1ns/1ns
`default_nettype none

module lsd_datapath (
    input wire logic ref_clk,
    input wire logic rst,
    input wire lsd_pkg::lsd_req_type req,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output var lsd_pkg::lsd_rsp_type rsp,
    output var lsd_pkg::lsd_flags_type flags,
    output var logic [31:0] reg_rdata
);
    import lsd_pkg::*;

    // ----------------------------------------
    // helper functions
    // ----------------------------------------

    // barrel shift of one kind; carry passes through at amount zero except for op_rotate_through_carry
    function automatic lsd_shout_type shift_unit(
        input lsd_op_type kind,
        input logic [31:0] x,
        input logic [7:0] amt,
        input logic cin
    );
        lsd_shout_type o;
        logic [32:0] t;
        logic [63:0] d;
        o.value = x;
        o.carry = cin;
        t = 33'h0;
        d = 64'h0000000000000000;
        unique case (kind)
            op_logical_left_shift: begin
                t = {1'b0, x} << amt;
                o.value = t[31:0];
                o.carry = t[32];
            end
            op_logical_right_shift: begin
                t = {x, 1'b0} >> amt;
                o.value = t[32:1];
                o.carry = t[0];
            end
            op_arith_right_shift: begin
                // [RL20] sign fill
                t = 33'($signed({x, 1'b0}) >>> amt);
                o.value = t[32:1];
                o.carry = t[0];
            end
            op_rotate_right: begin
                d = {x, x} >> amt[4:0];
                o.value = d[31:0];
                o.carry = d[31];
            end
            default: begin
                // [RL7] one place right
                // [RL20] old carry in, bit 0 out
                o.value = {cin, x[31:1]};
                o.carry = x[0];
            end
        endcase
        // [RL9] amount zero keeps carry
        if (kind != op_rotate_through_carry && amt == 8'h00) begin
            o.value = x;
            o.carry = cin;
        end
        return o;
    endfunction : shift_unit

    // count of zero bits above the highest set bit
    function automatic logic [5:0] count_leading(input logic [31:0] x);
        logic [5:0] n;
        logic seen;
        n = 6'h00;
        seen = 1'b0;
        for (int i = 31; i >= 0; i--) begin
            if (x[i]) begin
                seen = 1'b1;
            end
            if (!seen) begin
                n = n + 6'h01;
            end
        end
        return n;
    endfunction : count_leading

    // ----------------------------------------
    // state and next state
    // ----------------------------------------
    lsd_state_type st_r;
    lsd_state_type st_nxt;

    // decode helpers
    logic is_shift_op;
    logic is_logic_op;
    logic is_move_op;
    logic move_shifted;
    logic imm_ok;
    logic reject;
    logic hw_flag_upd;
    lsd_op_type shift_kind;
    logic [7:0] shift_amt;
    lsd_shout_type sh;
    logic [32:0] sum;
    logic [31:0] value;
    lsd_flags_type fl;

    // operation class and shift form of a copy
    always_comb begin
        is_logic_op = req.op inside {op_and, op_bitwise_or, op_bitwise_xor,
            op_clear_masked_bits, op_or_with_inverse};
        is_move_op = req.op inside {op_copy_value, op_inverted_copy};
        move_shifted = (req.op == op_copy_value) && (req.move_shift != mk_plain);
        // [RL16] copy with shift form maps onto the shift
        unique case (req.move_shift)
            mk_arith_right_shift: shift_kind = op_arith_right_shift;
            mk_logical_left_shift: shift_kind = op_logical_left_shift;
            mk_logical_right_shift: shift_kind = op_logical_right_shift;
            mk_rotate_right: shift_kind = op_rotate_right;
            default: shift_kind = op_rotate_through_carry;
        endcase
        if (!move_shifted) begin
            shift_kind = req.op;
        end
        is_shift_op = move_shifted || req.op inside {op_arith_right_shift,
            op_logical_left_shift, op_logical_right_shift, op_rotate_right,
            op_rotate_through_carry};
    end

    // shift amount selection and legality
    always_comb begin
        // [RL5] low byte of the amount register only
        if (req.amount_from_register) begin
            shift_amt = req.shift_amount_register[7:0];
        end else begin
            shift_amt = {2'b00, req.immediate_amount};
        end
        // [RL6] immediate range per shift kind
        imm_ok = 1'b1;
        if (is_shift_op && !req.amount_from_register) begin
            if (shift_kind inside {op_arith_right_shift, op_logical_right_shift}) begin
                imm_ok = req.immediate_amount >= IMM_RIGHT_MIN
                    && req.immediate_amount <= IMM_RIGHT_MAX;
            end else if (shift_kind != op_rotate_through_carry) begin
                imm_ok = req.immediate_amount <= IMM_LEFT_MAX;
            end
        end
        // [RL18] sp or pc only in plain unflagged copies
        reject = !imm_ok;
        if ((req.dest_is_pc || req.dest_is_sp)
            && !(req.op inside {op_compare_subtract, op_compare_add})) begin
            if (req.op != op_copy_value || req.set_flags
                || req.flexible_shifted || move_shifted) begin
                reject = 1'b1;
            end
        end
    end

    // [RL8] shifter reads the source and drives only the result path and the carry flag
    assign sh = shift_unit(shift_kind, req.source_operand, shift_amt, st_r.flags.c);

    // result and flag computation
    always_comb begin
        value = 32'h00000000;
        fl = st_r.flags;
        sum = 33'h0;
        hw_flag_upd = 1'b0;
        unique case (req.op)
            // [RL1] plain bitwise forms
            op_and: value = req.first_operand & req.flexible_operand;
            op_bitwise_or: value = req.first_operand | req.flexible_operand;
            op_bitwise_xor: value = req.first_operand ^ req.flexible_operand;
            // [RL2] and with inverse
            op_clear_masked_bits: value = req.first_operand & ~req.flexible_operand;
            // [RL3] or with inverse
            op_or_with_inverse: value = req.first_operand | ~req.flexible_operand;
            // [RL10] count of leading zeros
            op_leading_zero_count: value = {26'h0, count_leading(req.source_operand)};
            // [RL11] difference kept only for flags
            op_compare_subtract: begin
                sum = {1'b0, req.first_operand} + {1'b0, ~req.flexible_operand} + 33'h1;
                value = sum[31:0];
            end
            // [RL12] sum kept only for flags
            op_compare_add: begin
                sum = {1'b0, req.first_operand} + {1'b0, req.flexible_operand};
                value = sum[31:0];
            end
            // [RL14] copy of the flexible operand
            op_copy_value: value = req.flexible_operand;
            // [RL15] inverse copy
            op_inverted_copy: value = ~req.flexible_operand;
            // [RL19] top half loaded, bottom half kept
            op_upper_half_load: value = {req.immediate_value, req.dest_old[15:0]};
            // [RL14] zero-extended 16-bit immediate
            op_wide_immediate_load: value = {16'h0000, req.immediate_value};
            default: value = sh.value;
        endcase
        if (is_shift_op) begin
            value = sh.value;
        end
        if (req.valid && !reject) begin
            // [RL13] compares always set all four
            if (req.op == op_compare_subtract) begin
                hw_flag_upd = 1'b1;
                fl.c = sum[32];
                fl.v = (req.first_operand[31] != req.flexible_operand[31])
                    && (value[31] != req.first_operand[31]);
            end else if (req.op == op_compare_add) begin
                hw_flag_upd = 1'b1;
                fl.c = sum[32];
                fl.v = (req.first_operand[31] == req.flexible_operand[31])
                    && (value[31] != req.first_operand[31]);
            end else if (req.set_flags && is_shift_op) begin
                // [RL9] carry is last bit out
                hw_flag_upd = 1'b1;
                fl.c = sh.carry;
            end else if (req.set_flags && (is_logic_op || is_move_op)) begin
                // [RL4] operand carry, overflow kept
                hw_flag_upd = 1'b1;
                fl.c = req.flexible_carry;
            end
            if (hw_flag_upd) begin
                fl.n = value[31];
                fl.z = (value == 32'h00000000);
            end
        end
    end

    // next state: response, flags, counters and register reads
    always_comb begin
        st_nxt = st_r;
        st_nxt.rsp.done = req.valid;
        st_nxt.rsp.rejected = req.valid && reject;
        st_nxt.rsp.write_en = req.valid && !reject
            && !(req.op inside {op_compare_subtract, op_compare_add});
        st_nxt.rsp.result = value;
        st_nxt.rsp.branch = 1'b0;
        st_nxt.rsp.branch_addr = st_r.rsp.branch_addr;
        // [RL17] program counter target with bit 0 cleared
        if (st_nxt.rsp.write_en && req.dest_is_pc) begin
            st_nxt.rsp.write_en = 1'b0;
            st_nxt.rsp.branch = 1'b1;
            st_nxt.rsp.branch_addr = {value[31:1], 1'b0};
        end
        if (st_nxt.rsp.write_en || st_nxt.rsp.branch) begin
            st_nxt.last_result = value;
            st_nxt.op_count = st_r.op_count + 32'h00000001;
        end
        // software flag write loses to a hardware update
        if (hw_flag_upd) begin
            st_nxt.flags = fl;
        end else if (reg_wr && reg_addr == REG_FLAGS_OFF) begin
            st_nxt.flags = reg_wdata[3:0];
        end
        // read data valid only in the cycle after the strobe
        st_nxt.rd_data = 32'h00000000;
        if (reg_rd) begin
            unique case (reg_addr)
                REG_FLAGS_OFF: st_nxt.rd_data = {28'h0000000, st_r.flags};
                REG_RESULT_OFF: st_nxt.rd_data = st_r.last_result;
                REG_COUNT_OFF: st_nxt.rd_data = st_r.op_count;
                default: st_nxt.rd_data = 32'h00000000;
            endcase
        end
    end

    // state register
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_r.rsp <= '0;
            st_r.rsp.result <= RESULT_RESET;
            st_r.flags <= FLAGS_RESET;
            st_r.last_result <= RESULT_RESET;
            st_r.op_count <= COUNT_RESET;
            st_r.rd_data <= 32'h00000000;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from the state register
    assign rsp = st_r.rsp;
    assign flags = st_r.flags;
    assign reg_rdata = st_r.rd_data;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    // [RL2] clear masked bits value
    chk_clear_mask_value: assert property (req.valid && req.op == op_clear_masked_bits
        && !reject |=> rsp.write_en
        && rsp.result == ($past(req.first_operand) & ~$past(req.flexible_operand)))
        else $error("clear masked bits result wrong");

    // [RL3] or with inverse value
    chk_or_inverse_value: assert property (req.valid && req.op == op_or_with_inverse
        && !reject |=> rsp.result == ($past(req.first_operand) | ~$past(req.flexible_operand)))
        else $error("or with inverse result wrong");

    // [RL4] logical flag update keeps overflow
    chk_logic_vkeep: assert property (req.valid && is_logic_op && req.set_flags
        && !reject |=> flags.v == $past(flags.v) && flags.c == $past(req.flexible_carry))
        else $error("logical op disturbed overflow or carry");

    // [RL7] rotate through carry result
    chk_carry_rotate_result: assert property (req.valid && req.op == op_rotate_through_carry
        && !reject |=> rsp.result == {$past(flags.c), $past(req.source_operand[31:1])})
        else $error("rotate through carry result wrong");

    // [RL9] zero amount keeps carry
    chk_shift_czero: assert property (req.valid && is_shift_op && req.set_flags
        && !reject && shift_amt == 8'h00 && shift_kind != op_rotate_through_carry
        |=> flags.c == $past(flags.c))
        else $error("carry changed on zero shift");

    // [RL10] count of zero operand and no flag change
    chk_zero_count_empty: assert property (req.valid && req.op == op_leading_zero_count
        && !reject && req.source_operand == 32'h00000000
        && !(reg_wr && reg_addr == REG_FLAGS_OFF)
        |=> rsp.result == {26'h0, LZ_ALL_ZERO} && $stable(flags))
        else $error("leading zero count of zero wrong");

    // [RL11] compare writes nothing and sets zero on equal
    chk_compare_no_write: assert property (req.valid && req.op == op_compare_subtract
        && !reject && req.first_operand == req.flexible_operand
        |=> !rsp.write_en && flags.z && flags.c && !flags.n)
        else $error("compare wrote result or bad flags");

    // [RL6] out of range immediate is refused
    chk_imm_range: assert property (req.valid && req.op == op_logical_right_shift
        && !req.amount_from_register && req.immediate_amount == 6'h00
        |=> rsp.rejected && !rsp.write_en)
        else $error("illegal immediate amount accepted");

    // [RL17] branch target has bit 0 clear
    chk_pc_bit0: assert property (rsp.branch |-> !rsp.branch_addr[0] && !rsp.write_en)
        else $error("branch target bit 0 set");

    // [RL19] upper half load keeps low half
    chk_upper_half_low: assert property (req.valid && req.op == op_upper_half_load && !reject
        |=> rsp.result[15:0] == $past(req.dest_old[15:0])
        && rsp.result[31:16] == $past(req.immediate_value))
        else $error("upper half load changed low half");

endmodule : lsd_datapath

`default_nettype wire

// File: tb/lsd_core_model.sv
// lsd_core_model: stand-in for the decoder and register file in front of the datapath.
// assumes: bench hands over one request at a time; one destination register is modelled.
`timescale 1ns/1ns
`default_nettype none

module lsd_core_model (
    input wire logic ref_clk,
    input wire logic rst,
    input wire lsd_pkg::lsd_req_type cmd,
    input wire lsd_pkg::lsd_rsp_type rsp,
    output var lsd_pkg::lsd_req_type req
);
    import lsd_pkg::*;

    logic [31:0] dest_r;

    // destination register keeps what the datapath last wrote
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            dest_r <= 32'h00000000;
        end else if (rsp.write_en) begin
            dest_r <= rsp.result;
        end
    end

    // request with current destination value for the upper half load
    always_comb begin
        req = cmd;
        req.dest_old = dest_r;
        if (cmd.dest_is_pc || cmd.dest_is_sp) begin
            req.set_flags = 1'b0;
            req.move_shift = mk_plain;
            req.flexible_shifted = 1'b0;
        end
    end
endmodule : lsd_core_model

`default_nettype wire

// File: tb/tb_lsd_datapath.sv
// tb_lsd_datapath: random operations against a bench model, plus register port checks.
// assumes: 125 MHz clock; core model supplies the request and destination value.
`timescale 1ns/1ns
`default_nettype none

module tb_lsd_datapath;
    import lsd_pkg::*;

    logic ref_clk;
    logic rst;
    lsd_req_type cmd;
    lsd_req_type req;
    lsd_rsp_type rsp;
    lsd_flags_type flags;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata;
    logic [31:0] reg_rdata;
    logic reg_wr;
    logic reg_rd;
    logic [31:0] seed;
    logic [31:0] lr;
    logic [3:0] mf;
    int cnt;
    int n_fail;
    int n_checks;

    lsd_datapath lsd_datapath_i (.ref_clk(ref_clk), .rst(rst), .req(req), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .rsp(rsp), .flags(flags),
        .reg_rdata(reg_rdata));
    lsd_core_model lsd_core_model_i (.ref_clk(ref_clk), .rst(rst), .cmd(cmd), .rsp(rsp), .req(req));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    always #4 ref_clk = ~ref_clk;

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic test_done();
        $display("checks %0d, mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : test_done

    // shifter model, returns carry above value
    function automatic logic [32:0] sh(input lsd_op_type k, input logic [31:0] x, input logic [7:0] a,
            input logic ci);
        logic [32:0] t;
        logic [31:0] v;
        if (k == op_rotate_through_carry) return {x[0], ci, x[31:1]};
        if (a == 8'h00) return {ci, x};
        case (k)
            op_logical_left_shift: return {1'b0, x} << a;
            op_logical_right_shift: t = {x, 1'b0} >> a;
            op_arith_right_shift: t = $signed({x, 1'b0}) >>> (a > 8'h20 ? 8'h20 : a);
            default: begin
                v = (x >> a[4:0]) | (x << (32 - a[4:0]));
                return {v[31], v};
            end
        endcase
        return {t[0], t[32:1]};
    endfunction : sh

    // ----------------------------------------
    // one operation against the model
    // ----------------------------------------
    task automatic run(input lsd_req_type c);
        lsd_req_type q;
        lsd_op_type k;
        logic [32:0] s;
        logic [31:0] a, b, r;
        logic [7:0] amt;
        logic rj, we, br, so, cp, v;
        @(posedge ref_clk);
        cmd <= c;
        #1 q = req;
        a = q.first_operand;
        b = q.flexible_operand;
        amt = q.amount_from_register ? q.shift_amount_register[7:0] : {2'b00, q.immediate_amount};
        k = q.op;
        if (k == op_copy_value) case (q.move_shift)
            mk_arith_right_shift: k = op_arith_right_shift;
            mk_logical_left_shift: k = op_logical_left_shift;
            mk_logical_right_shift: k = op_logical_right_shift;
            mk_rotate_right: k = op_rotate_right;
            default: ;
        endcase
        so = k inside {op_arith_right_shift, op_logical_left_shift, op_logical_right_shift, op_rotate_right,
            op_rotate_through_carry};
        cp = k inside {op_compare_subtract, op_compare_add};
        rj = so && !q.amount_from_register && k != op_rotate_through_carry &&
            ((k inside {op_arith_right_shift, op_logical_right_shift}) ? (amt < 1 || amt > 32) : amt > 31);
        s = sh(k, q.source_operand, amt, mf[1]);
        r = s[31:0];
        v = 1'b0;
        case (k)
            op_and: r = a & b;
            op_bitwise_or: r = a | b;
            op_bitwise_xor: r = a ^ b;
            op_clear_masked_bits: r = a & ~b;
            op_or_with_inverse: r = a | ~b;
            op_copy_value: r = b;
            op_inverted_copy: r = ~b;
            op_upper_half_load: r = {q.immediate_value, q.dest_old[15:0]};
            op_wide_immediate_load: r = {16'h0000, q.immediate_value};
            op_leading_zero_count: begin
                r = 0;
                while (r < 32 && !q.source_operand[31 - r]) r++;
            end
            op_compare_subtract: begin
                s = {1'b0, a} + {1'b0, ~b} + 33'h1;
                r = s[31:0];
                v = (a[31] != b[31]) && (r[31] != a[31]);
            end
            op_compare_add: begin
                s = {1'b0, a} + {1'b0, b};
                r = s[31:0];
                v = (a[31] == b[31]) && (r[31] != a[31]);
            end
            default: ;
        endcase
        we = !rj && !cp && !q.dest_is_pc;
        br = q.dest_is_pc;
        if (!rj && cp) mf = {r[31], r == 0, s[32], v};
        else if (!rj && q.set_flags && so) mf[3:1] = {r[31], r == 0, s[32]};
        else if (q.set_flags && (k inside {op_and, op_bitwise_or, op_bitwise_xor, op_clear_masked_bits,
            op_or_with_inverse, op_copy_value, op_inverted_copy})) mf[3:1] = {r[31], r == 0, q.flexible_carry};
        if (we || br) begin
            cnt++;
            lr = r;
        end
        @(posedge ref_clk);
        cmd.valid <= 1'b0;
        #1;
        chk(32'(rsp.done), 32'h1);
        chk(32'({rsp.write_en, rsp.rejected, rsp.branch}), 32'({we, rj, br}));
        if (we || br) chk(rsp.result, r);
        if (br) chk(rsp.branch_addr, {b[31:1], 1'b0});
        chk(32'(flags), 32'(mf));
    endtask : run

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr

    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial begin
        #100000;
        n_fail++;
        test_done();
    end

    initial begin
        lsd_req_type c;
        logic [31:0] x, y;
        ref_clk = 1'b0;
        rst = 1'b1;
        cmd = '0;
        reg_addr = 8'h00;
        reg_wdata = 32'h00000000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        seed = 32'hE9B1ADE0;
        mf = FLAGS_RESET;
        cnt = 0;
        lr = RESULT_RESET;
        n_fail = 0;
        n_checks = 0;
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        rd(REG_FLAGS_OFF, 32'h00000000);
        rd(REG_COUNT_OFF, 32'h00000000);
        // every operation in turn with random operands and amounts
        for (int i = 0; i < 440; i++) begin
            x = rnd();
            y = rnd();
            c = '0;
            c.valid = 1'b1;
            c.op = lsd_op_type'(17'h00001 << (i % 17));
            c.set_flags = x[0];
            c.amount_from_register = x[1];
            c.flexible_carry = x[2];
            c.move_shift = lsd_move_shift_type'(5'h01 << (x[10:8] % 5));
            c.immediate_amount = 6'(x[23:16] % 34);
            c.dest_is_pc = (c.op == op_copy_value) && (x[6:4] == 3'h0);
            c.dest_is_sp = (c.op == op_copy_value) && (x[6:4] == 3'h1);
            c.shift_amount_register = {y[31:8], x[3] ? y[7:0] : 8'(x[31:24] % 36)};
            c.first_operand = rnd();
            c.flexible_operand = rnd();
            c.source_operand = rnd() >> (rnd() % 36);
            c.immediate_value = 16'(rnd());
            run(c);
            if (i % 55 == 0) rd(REG_FLAGS_OFF, 32'(mf));
        end
        rd(REG_COUNT_OFF, 32'(cnt));
        rd(REG_RESULT_OFF, lr);
        wr(REG_FLAGS_OFF, 32'h0000000F);
        mf = 4'hF;
        rd(REG_FLAGS_OFF, 32'h0000000F);
        wr(REG_COUNT_OFF, 32'h00000000);
        rd(REG_COUNT_OFF, 32'(cnt));
        rd(8'h0C, 32'h00000000);
        test_done();
    end
endmodule : tb_lsd_datapath

`default_nettype wire
